// [msf_defs.svh]
// msf_defs.svh: register offsets, reset values and timing of the shared fifo
// assumes: included by bare name wherever the map is needed
`ifndef MSF_DEFS_SVH
`define MSF_DEFS_SVH

// -----------------------------------------------------------------
// control slave, byte offsets
// -----------------------------------------------------------------
`define MSF_OFF_AF1   12'h000
`define MSF_OFF_AE1   12'h004
`define MSF_OFF_AF2   12'h008
`define MSF_OFF_AE2   12'h00C
// -----------------------------------------------------------------
// fill levels, one word per channel from this base
// -----------------------------------------------------------------
`define MSF_OFF_FILL  12'h100
`define MSF_THR_RST   32'h0000_0000
`define MSF_LAT_OUT   3

`endif

// [msf_pkg.sv]
// msf_pkg.sv: shared types of the multichannel shared fifo
// assumes: nothing beyond the defs header
`default_nettype none
package msf_pkg;
	typedef enum logic [1:0]
	{
		msf_resp_okay   = 2'b00,
		msf_resp_slverr = 2'b10
	} msf_resp_t;
	typedef enum logic [1:0]
	{
		msf_thr_af1 = 2'b00,
		msf_thr_ae1 = 2'b01,
		msf_thr_af2 = 2'b10,
		msf_thr_ae2 = 2'b11
	} msf_thr_t;
endpackage
`default_nettype wire

// [msf_top.sv]
// msf_top.sv: multichannel fifo, one segment per channel in one flop memory
// assumes: all ports on aclk; software on an axi4-lite slave
// Function
// [R1] data sink and source: ready/valid, latency zero
// [R2] status outputs: 2 bits, no backpressure
// [R3] channel field up to 16, packets, error
// [R4] channel count 1, 2, 4, 8 or 16
// [R5] symbols and bits per symbol 1..32
// [R6] error width 0..32, zero means none
// [R7] segment depth is two to address width
// [R8] all segments share one memory
// [R9] beat stored in its channel's segment
// [R10] errored packet discarded entirely
// [R11] forward only after a complete packet
// [R12] nothing available keeps source valid low
// [R13] data three cycles after request, one word
// [R14] request port optional, address selects channel
// [R15] no request port: channel 0 always requested
// [R16] shared almost-full/empty thresholds read/write
// [R17] fill level read latency one cycle
// [R18] status channels in round-robin, one per clock
// [R19] build options for each threshold output
// [R20] almost-full bit0: level at/above primary
// [R21] almost-empty bit0: level at/below primary
// [R22] bit1 uses the secondary thresholds
// [R23] read-only fill levels at channel times four
// [R24] per-channel wrapping pointers keep order
// [R25] sink ready low when segment full
`timescale 1ns/1ps
`default_nettype none
`include "msf_defs.svh"

module msf_top
#(
	parameter int NCH         = 4,
	parameter int SYM         = 4,
	parameter int BPS         = 8,
	parameter int ERR_W       = 1,
	parameter int AW          = 4,
	parameter bit USE_REQUEST = 1'b1,
	parameter bit USE_AF1     = 1'b1,
	parameter bit USE_AF2     = 1'b1,
	parameter bit USE_AE1     = 1'b1,
	parameter bit USE_AE2     = 1'b1
)
(
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic [11:0]                     s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [11:0]                     s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	input  wire logic [SYM*BPS-1:0]              in_data,
	input  wire logic                            in_valid,
	output logic                                 in_ready,
	input  wire logic [(NCH>1?$clog2(NCH):1)-1:0] in_channel,
	input  wire logic                            in_sop,
	input  wire logic                            in_eop,
	input  wire logic [(SYM>1?$clog2(SYM):1)-1:0] in_empty,
	input  wire logic [(ERR_W>0?ERR_W:1)-1:0]     in_error,
	output logic [SYM*BPS-1:0]                   out_data,
	output logic                                 out_valid,
	input  wire logic                            out_ready,
	output logic [(NCH>1?$clog2(NCH):1)-1:0]      out_channel,
	output logic                                 out_sop,
	output logic                                 out_eop,
	output logic [(SYM>1?$clog2(SYM):1)-1:0]      out_empty,
	output logic [(ERR_W>0?ERR_W:1)-1:0]          out_error,
	input  wire logic                            req_write,
	input  wire logic [(NCH>1?$clog2(NCH):1)-1:0] req_channel,
	output logic                                 req_busy,
	output logic                                 af_valid,
	output logic [(NCH>1?$clog2(NCH):1)-1:0]      af_channel,
	output logic [1:0]                           af_data,
	output logic                                 ae_valid,
	output logic [(NCH>1?$clog2(NCH):1)-1:0]      ae_channel,
	output logic [1:0]                           ae_data
);
	localparam int DW    = SYM * BPS;                     // see [R5]
	localparam int CW    = (NCH > 1) ? $clog2(NCH) : 1;   // see [R3] see [R4]
	localparam int MW    = (SYM > 1) ? $clog2(SYM) : 1;
	localparam int PW    = AW + 1;
	localparam int WW    = DW + MW + 2;
	localparam int DEPTH = 1 << AW;                       // see [R7]
	localparam logic [PW-1:0] DEPTH_L = PW'(DEPTH);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed
	{
		logic [NCH*DEPTH-1:0][WW-1:0] mem;
		logic [NCH-1:0][PW-1:0]       wr, cm, rd, pk;
		logic [NCH-1:0]               bad;
		logic                         s1_v, s1_hit, s2_v, s2_hit, out_v;
		logic [CW-1:0]                s1_ch, s2_ch, out_ch, st_ch;
		logic [WW-1:0]                s1_w, s2_w, out_w;
		logic [3:0][PW-1:0]           thr;
		logic                         aw_got, w_got, bvalid, rvalid;
		logic [11:0]                  awaddr;
		logic [31:0]                  wdata, rdata;
		logic [3:0]                   wstrb;
		logic [1:0]                   bresp, rresp, af, ae;
	} msf_state_t;

	msf_state_t q_ff;
	msf_state_t nxt_q;

	function automatic logic [PW-1:0] lvl(input logic [PW-1:0] w, input logic [PW-1:0] r);
		return w - r;
	endfunction

	function automatic logic [CW-1:0] ch_next(input logic [CW-1:0] c);
		return (NCH == 1) ? '0 : CW'(c + 1'b1);
	endfunction

	// returns {hit, threshold index}
	function automatic logic [2:0] ctrl_dec(input logic [11:0] a);
		return {(a[11:4] == 8'h00) && (a[1:0] == 2'b00), a[3:2]};
	endfunction

	// returns {hit, channel}
	function automatic logic [CW:0] fill_dec(input logic [11:0] a);
		logic [11:0] off;
		off = a - `MSF_OFF_FILL;
		return {(a >= `MSF_OFF_FILL) && (32'(off[11:2]) < NCH) && (off[1:0] == 2'b00),
			off[CW+1:2]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction

	localparam logic [3:0] THR_EN = {USE_AE2, USE_AF2, USE_AE1, USE_AF1}; // see [R19]

	logic [CW-1:0] rq_ch;
	logic          rq_v;
	logic          take;
	logic          hit;
	logic          acc;
	logic          err_now;
	logic          drop_now;
	logic [PW-1:0] base;
	logic [PW-1:0] st_lvl;
	logic [2:0]    cd;
	logic [CW:0]   fd;
	logic [31:0]   wm;

	// -----------------------------------------------------------------
	// request side
	// -----------------------------------------------------------------
	// without the port the fetch engine polls channel 0 forever
	assign rq_ch    = USE_REQUEST ? req_channel : '0;       // see [R15]
	assign rq_v     = USE_REQUEST ? req_write : 1'b1;       // see [R14]
	// one word in flight: later requests are refused until it leaves
	assign req_busy = q_ff.s1_v | q_ff.s2_v | (q_ff.out_v & ~out_ready); // see [R13]
	assign take     = rq_v & ~req_busy;
	assign hit      = take & (q_ff.pk[rq_ch] != '0);        // see [R11]
	assign in_ready = lvl(q_ff.wr[in_channel], q_ff.rd[in_channel]) != DEPTH_L; // see [R25]
	assign acc      = in_valid & in_ready;                  // see [R1]
	assign err_now  = (ERR_W > 0) && (|in_error);           // see [R6]
	assign drop_now = err_now | (~in_sop & q_ff.bad[in_channel]);
	assign st_lvl   = lvl(q_ff.wr[q_ff.st_ch], q_ff.rd[q_ff.st_ch]);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb
	begin
		nxt_q = q_ff;
		base  = in_sop ? q_ff.cm[in_channel] : q_ff.wr[in_channel];
		cd    = ctrl_dec(q_ff.awaddr);
		fd    = fill_dec(s_axi_araddr);
		wm    = '0;

		// fetch pipeline, three stages
		nxt_q.s1_v   = take;
		nxt_q.s1_hit = hit;
		nxt_q.s1_ch  = rq_ch;
		nxt_q.s1_w   = q_ff.mem[{rq_ch, q_ff.rd[rq_ch][AW-1:0]}]; // see [R8]
		nxt_q.s2_v   = q_ff.s1_v;
		nxt_q.s2_hit = q_ff.s1_hit;
		nxt_q.s2_ch  = q_ff.s1_ch;
		nxt_q.s2_w   = q_ff.s1_w;
		if (q_ff.out_v && out_ready)
			nxt_q.out_v = 1'b0;
		if (q_ff.s2_v)
		begin
			nxt_q.out_v  = q_ff.s2_hit;                     // see [R12]
			nxt_q.out_w  = q_ff.s2_w;
			nxt_q.out_ch = q_ff.s2_ch;
		end
		if (hit)
		begin
			nxt_q.rd[rq_ch] = q_ff.rd[rq_ch] + 1'b1;        // see [R24]
			if (q_ff.mem[{rq_ch, q_ff.rd[rq_ch][AW-1:0]}][WW-1])
				nxt_q.pk[rq_ch] = q_ff.pk[rq_ch] - 1'b1;
		end

		// sink: a start of packet rewinds any unfinished packet
		if (acc)
		begin
			nxt_q.mem[{in_channel, base[AW-1:0]}] = {in_eop, in_sop, in_empty, in_data}; // see [R9]
			nxt_q.wr[in_channel]  = base + 1'b1;            // see [R24]
			nxt_q.bad[in_channel] = drop_now;
			if (in_eop)
			begin
				nxt_q.bad[in_channel] = 1'b0;
				if (drop_now)
					nxt_q.wr[in_channel] = q_ff.cm[in_channel]; // see [R10]
				else
				begin
					nxt_q.cm[in_channel] = base + 1'b1;
					nxt_q.pk[in_channel] = nxt_q.pk[in_channel] + 1'b1;
				end
			end
		end

		// status round robin, registered one channel per clock
		nxt_q.st_ch = ch_next(q_ff.st_ch);                  // see [R18]
		nxt_q.af    = {USE_AF2 && (st_lvl >= q_ff.thr[msf_pkg::msf_thr_af2]), // see [R22]
			USE_AF1 && (st_lvl >= q_ff.thr[msf_pkg::msf_thr_af1])};          // see [R20]
		nxt_q.ae    = {USE_AE2 && (st_lvl <= q_ff.thr[msf_pkg::msf_thr_ae2]), // see [R22]
			USE_AE1 && (st_lvl <= q_ff.thr[msf_pkg::msf_thr_ae1])};          // see [R21]

		// axi write: address and data in either order
		if (q_ff.bvalid && s_axi_bready)
			nxt_q.bvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_q.aw_got = 1'b1;
			nxt_q.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_q.w_got = 1'b1;
			nxt_q.wdata = s_axi_wdata;
			nxt_q.wstrb = s_axi_wstrb;
		end
		if (q_ff.aw_got && q_ff.w_got)
		begin
			nxt_q.aw_got = 1'b0;
			nxt_q.w_got  = 1'b0;
			nxt_q.bvalid = 1'b1;
			nxt_q.bresp  = msf_pkg::msf_resp_slverr;
			if (cd[2])
			begin
				nxt_q.bresp = msf_pkg::msf_resp_okay;
				wm = merge(32'(q_ff.thr[cd[1:0]]), q_ff.wdata, q_ff.wstrb);
				if (THR_EN[cd[1:0]])
					nxt_q.thr[cd[1:0]] = wm[PW-1:0];        // see [R16]
			end
		end

		// axi read: answer on the next edge
		if (q_ff.rvalid && s_axi_rready)
			nxt_q.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_q.rvalid = 1'b1;
			nxt_q.rresp  = msf_pkg::msf_resp_slverr;
			nxt_q.rdata  = '0;
			if (ctrl_dec(s_axi_araddr) > 3'b011)
			begin
				nxt_q.rresp = msf_pkg::msf_resp_okay;
				if (THR_EN[s_axi_araddr[3:2]])
					nxt_q.rdata = 32'(q_ff.thr[s_axi_araddr[3:2]]); // see [R16]
			end
			else if (fd[CW])
			begin
				nxt_q.rresp = msf_pkg::msf_resp_okay;
				nxt_q.rdata = 32'(lvl(q_ff.wr[fd[CW-1:0]], q_ff.rd[fd[CW-1:0]])); // see [R17] see [R23]
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q_ff     <= '0;
			q_ff.thr <= {4{PW'(`MSF_THR_RST)}};
		end
		else
			q_ff <= nxt_q;
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign s_axi_awready = ~q_ff.aw_got & ~q_ff.bvalid;
	assign s_axi_wready  = ~q_ff.w_got & ~q_ff.bvalid;
	assign s_axi_bvalid  = q_ff.bvalid;
	assign s_axi_bresp   = q_ff.bresp;
	assign s_axi_arready = ~q_ff.rvalid;
	assign s_axi_rvalid  = q_ff.rvalid;
	assign s_axi_rdata   = q_ff.rdata;
	assign s_axi_rresp   = q_ff.rresp;
	assign out_valid     = q_ff.out_v;
	assign out_data      = q_ff.out_w[DW-1:0];
	assign out_empty     = q_ff.out_w[DW +: MW];
	assign out_sop       = q_ff.out_w[DW+MW];
	assign out_eop       = q_ff.out_w[WW-1];
	assign out_channel   = q_ff.out_ch;
	// errored packets never reach the output, so error is always clear
	assign out_error     = '0;
	assign af_valid      = 1'b1;                            // see [R2]
	assign ae_valid      = 1'b1;
	assign af_channel    = q_ff.st_ch - 1'b1;
	assign ae_channel    = q_ff.st_ch - 1'b1;
	assign af_data       = q_ff.af;
	assign ae_data       = q_ff.ae;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	logic [PW-1:0] pk_in;
	assign pk_in = q_ff.pk[in_channel];

	property p_full_stall; // see [R25]
		@(posedge aclk) disable iff (!aresetn)
		in_ready |-> lvl(q_ff.wr[in_channel], q_ff.rd[in_channel]) < DEPTH_L;
	endproperty
	a_full_stall: assert property (p_full_stall) else $error("sink ready while segment full");

	property p_req_lat; // see [R13]
		@(posedge aclk) disable iff (!aresetn)
		take && hit |=> !out_valid ##1 !out_valid ##1 out_valid;
	endproperty
	a_req_lat: assert property (p_req_lat) else $error("requested word not out after three cycles");

	property p_req_miss; // see [R12]
		@(posedge aclk) disable iff (!aresetn)
		take && !hit |-> ##1 !out_valid [*3];
	endproperty
	a_req_miss: assert property (p_req_miss) else $error("valid raised with no packet ready");

	property p_one_word; // see [R13]
		@(posedge aclk) disable iff (!aresetn)
		take |=> !take ##1 !take;
	endproperty
	a_one_word: assert property (p_one_word) else $error("second request taken while busy");

	property p_ch0_only; // see [R15]
		@(posedge aclk) disable iff (!aresetn)
		out_valid |-> (USE_REQUEST || out_channel == '0);
	endproperty
	a_ch0_only: assert property (p_ch0_only) else $error("channel other than 0 without request port");

	property p_fill_lat; // see [R17]
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_fill_lat: assert property (p_fill_lat) else $error("register read not answered in one cycle");

	property p_rr; // see [R18]
		@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> (af_channel == ch_next($past(af_channel))) && (ae_channel == af_channel);
	endproperty
	a_rr: assert property (p_rr) else $error("status channel out of round-robin order");

	property p_af0; // see [R20]
		@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> af_data[0] == (USE_AF1 && ($past(st_lvl) >= $past(q_ff.thr[0])));
	endproperty
	a_af0: assert property (p_af0) else $error("almost-full bit 0 wrong");

	property p_ae0; // see [R21]
		@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> ae_data[0] == (USE_AE1 && ($past(st_lvl) <= $past(q_ff.thr[1])));
	endproperty
	a_ae0: assert property (p_ae0) else $error("almost-empty bit 0 wrong");

	property p_drop; // see [R10]
		@(posedge aclk) disable iff (!aresetn)
		acc && in_eop && drop_now && !(hit && rq_ch == in_channel)
		|=> q_ff.pk[$past(in_channel)] == $past(pk_in);
	endproperty
	a_drop: assert property (p_drop) else $error("errored packet counted as complete");

endmodule
`default_nettype wire

// [msf_sched_model.sv]
// msf_sched_model.sv: scheduler model, asks one word of a channel and drains the source
// assumes: shares aclk with the fifo; the bench holds go high until done
`timescale 1ns/1ps
`default_nettype none
module msf_sched_model
#(
	parameter int CW = 2,
	parameter int DW = 32
)
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          go,
	input  wire logic [CW-1:0] chan,
	input  wire logic [3:0]    stall,
	input  wire logic          req_busy,
	input  wire logic          out_valid,
	input  wire logic [DW-1:0] out_data,
	output logic               req_write,
	output logic [CW-1:0]      req_channel,
	output logic               out_ready,
	output logic [DW-1:0]      got,
	output logic [3:0]         lat,
	output logic               none,
	output logic               done
);
	logic [1:0] st_ff;
	logic [3:0] cnt_ff;
	logic       seen_ff;
	assign done = (st_ff == 2'd3);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= 2'd0;
			cnt_ff <= 4'h0;
			seen_ff <= 1'b0;
			req_write <= 1'b0;
			req_channel <= '0;
			out_ready <= 1'b0;
			got <= '0;
			lat <= 4'h0;
			none <= 1'b0;
		end
		else
		begin
			case (st_ff)
				2'd0:
				begin
					if (go)
					begin
						req_write <= 1'b1;
						req_channel <= chan;
						none <= 1'b0;
						seen_ff <= 1'b0;
						st_ff <= 2'd1;
					end
				end
				2'd1:
				begin
					// taken at this edge; idle channel lines show the inverse, not a stale value
					if (!req_busy)
					begin
						req_write <= 1'b0;
						req_channel <= ~req_channel;
						cnt_ff <= 4'h1;
						out_ready <= (stall == 4'h0);
						st_ff <= 2'd2;
					end
				end
				2'd2:
				begin
					cnt_ff <= cnt_ff + 4'h1;
					if (out_valid && !seen_ff)
					begin
						lat <= cnt_ff;
						got <= out_data;
						seen_ff <= 1'b1;
					end
					// no second word is asked until this one is taken
					if (out_valid && out_ready)
					begin
						out_ready <= 1'b0;
						st_ff <= 2'd3;
					end
					else if (seen_ff && cnt_ff >= lat + stall)
						out_ready <= 1'b1;
					else if (!out_valid && cnt_ff == 4'hA)
					begin
						none <= 1'b1;
						st_ff <= 2'd3;
					end
				end
				default:
				begin
					if (!go)
						st_ff <= 2'd0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [multichannel_shared_fifo_tb_top.sv]
// multichannel_shared_fifo_tb_top.sv: self-checking bench of the shared fifo
// assumes: msf_top with default parameters (4 channels, depth 16, 32-bit words)
`timescale 1ns/1ps
`default_nettype none
`include "msf_defs.svh"
module multichannel_shared_fifo_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, in_data = '0, out_data, got;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, in_channel = '0, out_channel, req_channel, chan = '0;
	logic        in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, in_ready, out_valid, out_ready;
	logic [0:0]  in_error = '0, out_error;
	logic        req_write, req_busy, out_sop, out_eop, go = 1'b0, none, done;
	logic [1:0]  af_channel, ae_channel, af_data, ae_data, r, out_empty;
	logic        af_valid, ae_valid;
	logic [3:0]  stall = '0, lat;
	logic [31:0] th [4];
	logic [31:0] lev [4];
	int          n_fail = 0, num_checks = 0, k;
	always #12.5 aclk = ~aclk;
	msf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .in_data, .in_valid, .in_ready, .in_channel, .in_sop, .in_eop, .in_empty(2'h0),
		.in_error, .out_data, .out_valid, .out_ready, .out_channel, .out_sop, .out_eop, .out_empty,
		.out_error, .req_write, .req_channel, .req_busy, .af_valid, .af_channel, .af_data, .ae_valid,
		.ae_channel, .ae_data);
	msf_sched_model u_sched (.aclk, .aresetn, .go, .chan, .stall, .req_busy, .out_valid, .out_data,
		.req_write, .req_channel, .out_ready, .got, .lat, .none, .done);
	// -----------------------------------------------------------------
	// checking and closing
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
			n_fail++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("CHECK FAILED handshake expected answer seen none");
		close_out();
	endtask
	// -----------------------------------------------------------------
	// bus, sink, request and status tasks; each is entered just after an edge
	// -----------------------------------------------------------------
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (i == 40)
			hang();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (i == 40)
			hang();
		chk("read data", s_axi_rdata, exp);
		chk("read resp", s_axi_rresp, er);
		chk("read latency", i, 1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic send_pkt(input logic [1:0] ch, input int n, input logic [31:0] base, input logic err,
		input logic fin);
		int b, i;
		for (b = 0; b < n; b++)
		begin
			in_channel <= ch;
			in_data <= base + 32'(b);
			in_sop <= (b == 0);
			in_eop <= fin && (b == n - 1);
			in_error <= err;
			in_valid <= 1'b1;
			for (i = 0; i < 40; i++)
			begin
				@(posedge aclk);
				if (in_ready)
					break;
			end
			if (i == 40)
				hang();
		end
		in_valid <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic ask(input logic [1:0] ch, input logic [3:0] sl, input logic [31:0] exp, input logic nd,
		input logic [1:0] fl);
		int i;
		logic [6:0] fr;
		fr = '0;
		go <= 1'b1;
		chan <= ch;
		stall <= sl;
		for (i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			// framing only stands while valid, so take it then
			if (out_valid)
				fr = {out_channel, out_sop, out_eop, out_empty, out_error};
			if (done)
				break;
		end
		if (i == 40)
			hang();
		chk("nothing returned", none, nd);
		if (!nd)
		begin
			chk("out word", got, exp);
			chk("out latency", lat, 3);
			chk("out channel and framing", fr, {ch, fl, 3'h0});
		end
		go <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic sts();
		int i;
		logic [1:0] pc;
		logic [1:0] nx;
		@(posedge aclk);
		pc = af_channel;
		for (i = 0; i < 8; i++)
		begin
			@(posedge aclk);
			// two bits on purpose, so channel 3 wraps to 0
			nx = pc + 2'd1;
			chk("status valid", {af_valid, ae_valid}, 2'b11);
			chk("af channel", af_channel, nx);
			chk("ae channel", ae_channel, nx);
			chk("af bits", af_data, {lev[nx] >= th[2], lev[nx] >= th[0]});
			chk("ae bits", ae_data, {lev[nx] <= th[3], lev[nx] <= th[1]});
			pc = af_channel;
		end
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (k = 0; k < 4; k++)
			rd_chk(`MSF_OFF_AF1 + 12'(4 * k), `MSF_THR_RST, msf_pkg::msf_resp_okay);
		for (k = 0; k < 4; k++)
			rd_chk(`MSF_OFF_FILL + 12'(4 * k), 32'h0, msf_pkg::msf_resp_okay);
		rd_chk(12'h080, 32'h0, msf_pkg::msf_resp_slverr);
		th = '{32'h10, 32'h0, 32'h1, 32'h1};
		for (k = 0; k < 4; k++)
		begin
			axw(`MSF_OFF_AF1 + 12'(4 * k), th[k], r);
			chk("write resp", r, msf_pkg::msf_resp_okay);
			rd_chk(`MSF_OFF_AF1 + 12'(4 * k), th[k], msf_pkg::msf_resp_okay);
		end
		// fill levels refuse writes and keep their value
		axw(`MSF_OFF_FILL + 12'h4, 32'h5, r);
		chk("fill write resp", r, msf_pkg::msf_resp_slverr);
		send_pkt(2'd1, 2, 32'h1100_00A0, 1'b0, 1'b1);
		rd_chk(`MSF_OFF_FILL + 12'h4, 32'h2, msf_pkg::msf_resp_okay);
		send_pkt(2'd3, 1, 32'h3300_00C0, 1'b0, 1'b0);
		send_pkt(2'd0, 3, 32'h2200_00B0, 1'b1, 1'b1);
		rd_chk(`MSF_OFF_FILL, 32'h0, msf_pkg::msf_resp_okay);
		ask(2'd2, 4'h0, 32'h0, 1'b1, 2'b00);
		ask(2'd3, 4'h0, 32'h0, 1'b1, 2'b00);
		ask(2'd0, 4'h0, 32'h0, 1'b1, 2'b00);
		ask(2'd1, 4'h0, 32'h1100_00A0, 1'b0, 2'b10);
		ask(2'd1, 4'h3, 32'h1100_00A1, 1'b0, 2'b01);
		ask(2'd1, 4'h0, 32'h0, 1'b1, 2'b00);
		rd_chk(`MSF_OFF_FILL + 12'h4, 32'h0, msf_pkg::msf_resp_okay);
		send_pkt(2'd2, 16, 32'h4400_00D0, 1'b0, 1'b1);
		rd_chk(`MSF_OFF_FILL + 12'h8, 32'h10, msf_pkg::msf_resp_okay);
		in_channel <= 2'd2;
		@(posedge aclk);
		chk("in ready full", in_ready, 1'b0);
		in_channel <= 2'd1;
		@(posedge aclk);
		chk("in ready room", in_ready, 1'b1);
		lev = '{32'h0, 32'h0, 32'h10, 32'h1};
		sts();
		close_out();
	end
endmodule
`default_nettype wire
